/* dnp_defs.svh */
// Notes on behaviour
// R1: User requests initialization before first command.
// R2: Init-done pulses one cycle after levelling.
// R3: User drops init request on done pulse.
// R4: Command fields valid while command valid high.
// R5: Command ready is a one-cycle pulse.
// R6: Command code is four bits wide.
// R7: Repeat count 1..32; zero means 32.
// R8: Repeats advance address by burst length.
// R9: On-the-fly mode: 0 chop four, 1 eight.
// R10: Burst length sampled only at acceptance.
// R11: Write-data request; user returns word and mask.
// R12: User word is gearing times memory width.
// R13: One mask bit per byte suppresses write.
// R14: Read valid marks exactly the valid cycles.
// R15: External refresh request answered by done pulse.
// R16: Write-levelling failure flag raised on failure.
// R17: Read-training failure flag raised on failure.
// R18: Termination control per chip select, active high.
// R19: All user signals on system clock.
// R20: Asynchronous low reset clears whole controller; the store memory is not reset, ctrl loads 2'h2 and the state registers load ST_INIT and IS_IDLE.
// R21: User holds command fields until ready.
// R22: Read words return in command order.
`ifndef DNP_DEFS_SVH
`define DNP_DEFS_SVH

`define DNP_DATA_W 16
`define DNP_GEAR 8
`define DNP_USER_W (`DNP_DATA_W * `DNP_GEAR) // [R12]
`define DNP_MASK_W (`DNP_USER_W / 8)
`define DNP_ADDR_W 27
`define DNP_CS_W 1
`define DNP_CMD_W 4
`define DNP_BCNT_W 5
`define DNP_REP_W 6
`define DNP_REP_MAX 6'h20
`define DNP_REP_ONE 6'h01

`define DNP_CMD_READ 4'h1
`define DNP_CMD_WRITE 4'h2
`define DNP_CMD_READA 4'h3
`define DNP_CMD_WRITEA 4'h4
`define DNP_CMD_REFRESH 4'h5

`define DNP_STEP_BC4 27'h0000004
`define DNP_STEP_BL8 27'h0000008

`define DNP_STORE_AW 4
`define DNP_STORE_LSB 2

`define DNP_REG_AW 4
`define DNP_REG_DW 8
`define DNP_REG_CTRL 4'h0
`define DNP_REG_STAT 4'h1
`define DNP_CTRL_OFLY 0
`define DNP_CTRL_BL8 1
`define DNP_CTRL_RST 2'h2
`define DNP_STAT_DONE 0
`define DNP_STAT_WL 1
`define DNP_STAT_RT 2
`define DNP_STAT_BUSY 3

`define DNP_TMR_W 12
`define DNP_CLK_NS 8
`define DNP_INIT_NS 2000
`define DNP_LVL_NS 800
`define DNP_TRFC_NS 160

`endif

/* dnp_pkg.sv */
`default_nettype none
`include "dnp_defs.svh"
package dnp_pkg;
	typedef enum logic [6:0] {
		ST_INIT = 7'h01,
		ST_IDLE = 7'h02,
		ST_ACC = 7'h04,
		ST_WR_REQ = 7'h08,
		ST_WR_DAT = 7'h10,
		ST_RD = 7'h20,
		ST_REF = 7'h40
	} dnp_state_t;

	typedef enum logic [3:0] {
		IS_IDLE = 4'h1,
		IS_MEM = 4'h2,
		IS_LVL = 4'h4,
		IS_DONE = 4'h8
	} dnp_init_state_t;

	// Least times round up to whole cycles, never below one.
	function automatic logic [`DNP_TMR_W-1:0] dnp_cycles(input int unsigned ns);
		int unsigned c;
		c = (ns + `DNP_CLK_NS - 1) / `DNP_CLK_NS;
		if (c == 0) begin
			c = 1;
		end
		return c[`DNP_TMR_W-1:0];
	endfunction
endpackage
`default_nettype wire

/* dnp_init.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dnp_defs.svh"
module dnp_init import dnp_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic init_start_i,
	input wire logic phy_wl_fail_i,
	input wire logic phy_rt_fail_i,
	output logic done_pulse_o,
	output logic ready_o,
	output logic write_levelling_failure,
	output logic read_training_failure
);
	typedef struct packed {
		dnp_init_state_t st;
		logic [`DNP_TMR_W-1:0] tmr;
		logic [1:0] wl_sync;
		logic [1:0] rt_sync;
		logic done;
		logic ready;
		logic wl_err;
		logic rt_err;
	} dnp_init_s_t;

	dnp_init_s_t q, d;

	always_comb begin
		d = q;
		d.done = 1'b0;
		// Failure pins come from the PHY domain; two stages before use.
		d.wl_sync = {q.wl_sync[0], phy_wl_fail_i};
		d.rt_sync = {q.rt_sync[0], phy_rt_fail_i};
		case (q.st)
			IS_IDLE: begin
				if (init_start_i) begin
					d.st = IS_MEM;
					d.tmr = dnp_cycles(`DNP_INIT_NS);
				end
			end
			IS_MEM: begin
				d.tmr = q.tmr - 1'b1;
				if (q.tmr == `DNP_TMR_W'(1)) begin
					d.st = IS_LVL;
					d.tmr = dnp_cycles(`DNP_LVL_NS);
				end
			end
			IS_LVL: begin
				d.tmr = q.tmr - 1'b1;
				if (q.tmr == `DNP_TMR_W'(1)) begin
					d.st = IS_DONE;
					d.done = 1'b1; // [R2]
					d.ready = 1'b1;
					d.wl_err = q.wl_sync[1]; // [R16]
					d.rt_err = q.rt_sync[1]; // [R17]
				end
			end
			IS_DONE: begin
				d.st = IS_DONE;
			end
			default: begin
				d.st = IS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '{st: IS_IDLE, default: '0}; // [R20]
		end else begin
			q <= d;
		end
	end

	assign done_pulse_o = q.done;
	assign ready_o = q.ready;
	assign write_levelling_failure = q.wl_err;
	assign read_training_failure = q.rt_err;
endmodule
`default_nettype wire

/* dnp_store.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dnp_defs.svh"
module dnp_store import dnp_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [`DNP_STORE_AW-1:0] idx_i,
	input wire logic [`DNP_USER_W-1:0] wdata_i,
	input wire logic [`DNP_MASK_W-1:0] wmask_i,
	output logic [`DNP_USER_W-1:0] rdata_o
);
	logic [`DNP_USER_W-1:0] mem [0:(1<<`DNP_STORE_AW)-1];
	logic [`DNP_USER_W-1:0] rdata_q, rdata_d;

	// Mask bit set keeps the old byte.
	always_ff @(posedge clk_sys_i) begin
		if (wr_en_i) begin
			for (int b = 0; b < `DNP_MASK_W; b++) begin
				if (!wmask_i[b]) begin
					mem[idx_i][b*8 +: 8] <= wdata_i[b*8 +: 8]; // [R13]
				end
			end
		end
	end

	always_comb begin
		rdata_d = rdata_q;
		if (rd_en_i) begin
			rdata_d = mem[idx_i];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign rdata_o = rdata_q;

	property p_mask_keeps;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(wr_en_i && wmask_i[0]) |=> (mem[$past(idx_i)][7:0] == $past(mem[idx_i][7:0]));
	endproperty
	a_mask_keeps: assert property (p_mask_keeps) else $error("masked byte was written"); // [R13]
endmodule
`default_nettype wire

/* dnp_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dnp_defs.svh"
module dnp_port import dnp_pkg::*; (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic init_start_i,
	output logic init_done_o,
	input wire logic cmd_valid_i,
	output logic cmd_rdy_o,
	input wire logic [`DNP_CMD_W-1:0] cmd_i,
	input wire logic [`DNP_BCNT_W-1:0] cmd_burst_cnt_i,
	input wire logic ofly_burst_len_i,
	input wire logic [`DNP_ADDR_W-1:0] addr_i,
	output logic datain_rdy_o,
	input wire logic [`DNP_USER_W-1:0] write_data_i,
	input wire logic [`DNP_MASK_W-1:0] data_mask_i,
	output logic [`DNP_USER_W-1:0] read_data_o,
	output logic read_data_valid_o,
	input wire logic ext_auto_ref_i,
	output logic ext_auto_ref_ack_o,
	output logic write_levelling_failure_o,
	output logic read_training_failure_o,
	output logic [`DNP_CS_W-1:0] memory_termination_control_o,
	input wire logic phy_wl_fail_i,
	input wire logic phy_rt_fail_i,
	input wire logic [`DNP_REG_AW-1:0] reg_addr_i,
	input wire logic [`DNP_REG_DW-1:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [`DNP_REG_DW-1:0] reg_rdata_o
);
	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		dnp_state_t st;
		logic init_done;
		logic wl_err;
		logic rt_err;
		logic cmd_rdy;
		logic din_rdy;
		logic rd_pend;
		logic rd_valid;
		logic [`DNP_USER_W-1:0] rd_data;
		logic ref_ack;
		logic ext_ref;
		logic [`DNP_CS_W-1:0] odt;
		logic [`DNP_CMD_W-1:0] cmd;
		logic [`DNP_ADDR_W-1:0] addr;
		logic [`DNP_ADDR_W-1:0] step;
		logic [`DNP_REP_W-1:0] rem;
		logic [`DNP_TMR_W-1:0] tmr;
		logic [1:0] ctrl;
		logic [`DNP_REG_DW-1:0] reg_rdata;
	} dnp_port_s_t;

	dnp_port_s_t q, d;

	logic init_pulse;
	logic init_ready;
	logic init_wl_err;
	logic init_rt_err;
	logic [`DNP_USER_W-1:0] store_rdata;
	logic store_wr;
	logic store_rd;
	logic accept;

	function automatic logic [`DNP_REP_W-1:0] rep_count(input logic [`DNP_BCNT_W-1:0] c);
		// Zero stands for the largest repeat count.
		return (c == '0) ? `DNP_REP_MAX : {1'b0, c}; // [R7]
	endfunction

	function automatic logic [`DNP_ADDR_W-1:0] burst_step(input logic [1:0] ctrl, input logic ofly);
		logic bl8;
		bl8 = ctrl[`DNP_CTRL_OFLY] ? ofly : ctrl[`DNP_CTRL_BL8]; // [R9]
		return bl8 ? `DNP_STEP_BL8 : `DNP_STEP_BC4;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Initialization sequencing and the backing store.

	dnp_init u_init (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.init_start_i(init_start_i), // [R1]
		.phy_wl_fail_i(phy_wl_fail_i),
		.phy_rt_fail_i(phy_rt_fail_i),
		.done_pulse_o(init_pulse),
		.ready_o(init_ready),
		.write_levelling_failure(init_wl_err),
		.read_training_failure(init_rt_err)
	);

	// Writes go straight from the user port into the store in the data cycle.
	assign store_wr = (q.st == ST_WR_DAT);
	assign store_rd = (q.st == ST_RD);

	dnp_store u_store (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(store_wr),
		.rd_en_i(store_rd),
		.idx_i(q.addr[`DNP_STORE_LSB +: `DNP_STORE_AW]),
		.wdata_i(write_data_i), // [R11]
		.wmask_i(data_mask_i), // [R13]
		.rdata_o(store_rdata)
	);

	assign accept = (q.st == ST_ACC) && cmd_valid_i;

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer.

	always_comb begin
		d = q;
		d.init_done = init_pulse; // [R2]
		d.wl_err = init_wl_err; // [R16]
		d.rt_err = init_rt_err; // [R17]
		d.cmd_rdy = 1'b0;
		d.din_rdy = 1'b0;
		d.ref_ack = 1'b0;
		d.rd_pend = store_rd;
		// The store answers one cycle after a read; data are re-registered so that
		// the port is driven from a flop, which keeps words in issue order.
		d.rd_valid = q.rd_pend; // [R14] [R22]
		if (q.rd_pend) begin
			d.rd_data = store_rdata;
		end
		d.odt = '0;
		d.reg_rdata = '0;

		case (q.st)
			ST_INIT: begin
				if (init_ready) begin
					d.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (cmd_valid_i) begin
					d.cmd_rdy = 1'b1; // [R5]
					d.st = ST_ACC;
				end else if (ext_auto_ref_i && !q.ref_ack) begin
					// The user drops its request on the edge that samples the acknowledge, so
					// the stale level seen in that cycle must not start a second refresh.
					d.st = ST_REF; // [R15]
					d.ext_ref = 1'b1;
					d.tmr = dnp_cycles(`DNP_TRFC_NS);
				end
			end
			ST_ACC: begin
				d.st = ST_IDLE;
				// Fields and burst length are captured only with ready high.
				if (cmd_valid_i) begin // [R4] [R21]
					d.cmd = cmd_i; // [R6]
					d.addr = addr_i;
					d.rem = rep_count(cmd_burst_cnt_i); // [R7]
					d.step = burst_step(q.ctrl, ofly_burst_len_i); // [R10]
					case (cmd_i)
						`DNP_CMD_WRITE, `DNP_CMD_WRITEA: begin
							d.st = ST_WR_REQ;
							d.din_rdy = 1'b1; // [R11]
							d.odt = '1; // [R18]
						end
						`DNP_CMD_READ, `DNP_CMD_READA: begin
							d.st = ST_RD;
						end
						`DNP_CMD_REFRESH: begin
							d.st = ST_REF;
							d.ext_ref = 1'b0;
							d.tmr = dnp_cycles(`DNP_TRFC_NS);
						end
						default: begin
							d.st = ST_IDLE;
						end
					endcase
				end
			end
			ST_WR_REQ: begin
				d.st = ST_WR_DAT;
				d.odt = '1; // [R18]
			end
			ST_WR_DAT: begin
				if (q.rem == `DNP_REP_ONE) begin
					d.st = ST_IDLE;
				end else begin
					d.rem = q.rem - 1'b1; // [R7]
					d.addr = q.addr + q.step; // [R8]
					d.st = ST_WR_REQ;
					d.din_rdy = 1'b1;
					d.odt = '1;
				end
			end
			ST_RD: begin
				if (q.rem == `DNP_REP_ONE) begin
					d.st = ST_IDLE;
				end else begin
					d.rem = q.rem - 1'b1; // [R7]
					d.addr = q.addr + q.step; // [R8]
				end
			end
			ST_REF: begin
				d.tmr = q.tmr - 1'b1;
				if (q.tmr == `DNP_TMR_W'(1)) begin
					d.st = ST_IDLE;
					d.ref_ack = q.ext_ref; // [R15]
					d.ext_ref = 1'b0;
				end
			end
			default: begin
				d.st = ST_INIT;
			end
		endcase

		////////////////////////////////////////////////////////////////////////////////
		// Register port: control steers burst length, status shows core state.

		if (reg_we_i && (reg_addr_i == `DNP_REG_CTRL)) begin
			d.ctrl = reg_wdata_i[1:0];
		end
		if (reg_re_i) begin
			case (reg_addr_i)
				`DNP_REG_CTRL: begin
					d.reg_rdata[1:0] = q.ctrl;
				end
				`DNP_REG_STAT: begin
					d.reg_rdata[`DNP_STAT_DONE] = init_ready;
					d.reg_rdata[`DNP_STAT_WL] = q.wl_err;
					d.reg_rdata[`DNP_STAT_RT] = q.rt_err;
					d.reg_rdata[`DNP_STAT_BUSY] = (q.st != ST_IDLE);
				end
				default: begin
					d.reg_rdata = '0;
				end
			endcase
		end
	end

	// Everything on the one system clock, cleared by the async reset except st, which loads ST_INIT, and ctrl, which loads DNP_CTRL_RST.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin // [R19]
		if (!rst_n_i) begin
			q <= '{st: ST_INIT, ctrl: `DNP_CTRL_RST, default: '0}; // [R20]
		end else begin
			q <= d;
		end
	end

	assign init_done_o = q.init_done;
	assign cmd_rdy_o = q.cmd_rdy;
	assign datain_rdy_o = q.din_rdy;
	assign read_data_o = q.rd_data;
	assign read_data_valid_o = q.rd_valid;
	assign ext_auto_ref_ack_o = q.ref_ack;
	assign write_levelling_failure_o = q.wl_err;
	assign read_training_failure_o = q.rt_err;
	assign memory_termination_control_o = q.odt;
	assign reg_rdata_o = q.reg_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	property p_init_pulse;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		$rose(init_done_o) |=> !init_done_o;
	endproperty
	a_init_pulse: assert property (p_init_pulse) else $error("init done longer than one cycle"); // [R2]

	property p_rdy_pulse;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		cmd_rdy_o |=> !cmd_rdy_o;
	endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("command ready longer than one cycle"); // [R5]

	property p_rdy_cause;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		cmd_rdy_o |-> $past(cmd_valid_i) && $past(q.st == ST_IDLE);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("ready without a valid command"); // [R4]

	property p_rep_zero;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(accept && cmd_burst_cnt_i == '0 && cmd_i == `DNP_CMD_READ) |=> (q.rem == `DNP_REP_MAX) && (q.st == ST_RD);
	endproperty
	a_rep_zero: assert property (p_rep_zero) else $error("zero count did not give full repeats"); // [R7]

	property p_addr_step;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q.st == ST_RD && q.rem != `DNP_REP_ONE) |=> (q.addr == $past(q.addr) + $past(q.step));
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("repeat address did not advance"); // [R8]

	property p_ofly_len;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(accept && q.ctrl[`DNP_CTRL_OFLY]) |=>
			(q.step == ($past(ofly_burst_len_i) ? `DNP_STEP_BL8 : `DNP_STEP_BC4));
	endproperty
	a_ofly_len: assert property (p_ofly_len) else $error("burst length input not honoured"); // [R9] [R10]

	property p_rd_valid;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		read_data_valid_o |-> $past(store_rd, 2);
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read valid without a read issued"); // [R14]

	property p_rd_issue;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		store_rd |-> ##2 read_data_valid_o;
	endproperty
	a_rd_issue: assert property (p_rd_issue) else $error("issued read gave no data"); // [R14] [R22]

	property p_ref_ack;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(q.st == ST_IDLE && !cmd_valid_i && ext_auto_ref_i && !ext_auto_ref_ack_o) |-> ##[19:21] ext_auto_ref_ack_o;
	endproperty
	a_ref_ack: assert property (p_ref_ack) else $error("refresh not acknowledged in time"); // [R15]

	property p_odt;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		datain_rdy_o |-> memory_termination_control_o == '1 ##1 memory_termination_control_o == '1;
	endproperty
	a_odt: assert property (p_odt) else $error("termination off during write"); // [R18]

	property p_fail_flags;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		init_done_o |-> (write_levelling_failure_o == init_wl_err) && (read_training_failure_o == init_rt_err);
	endproperty
	a_fail_flags: assert property (p_fail_flags) else $error("failure flags not valid at init done"); // [R16] [R17]
endmodule
`default_nettype wire

/* dnp_dummy_never.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* dnp_user_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dnp_user_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic init_done_i,
	output logic init_start_o
);
	logic started_q;

	// One request per reset, so a late done pulse cannot start a second run.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_start_o <= 1'b0;
			started_q <= 1'b0;
		end else if (init_done_i) begin
			init_start_o <= 1'b0;
		end else if (!started_q) begin
			init_start_o <= 1'b1;
			started_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* ddr3_native_user_port_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "dnp_defs.svh"
module ddr3_native_user_port_bench;
	logic clk = 1'b0, rst_n = 1'b0, init_start, init_done, cv = 1'b0, crdy, ofly = 1'b0, drdy, rdv;
	logic ref_req = 1'b0, ref_ack, wlf, rtf, rwe = 1'b0, rre = 1'b0, wlp = 1'b0, rtp = 1'b0;
	logic [3:0] cmd = 4'h0, ra = 4'h0;
	logic [4:0] cnt = 5'h01;
	logic [26:0] addr = 27'h0;
	logic [127:0] wd = 128'h0, rd;
	logic [15:0] dm = 16'h0;
	logic [0:0] odt;
	logic [7:0] rwd = 8'h0, rrd, v;
	logic [127:0] wq[$], got[$];
	int n_mismatch = 0, tests_run = 0;
	localparam logic [127:0] W0 = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] W1 = 128'hfedcba98765432100123456789abcdef;
	localparam logic [127:0] W2 = 128'h5a5a5a5a0f0f0f0fa5a5a5a5f0f0f0f0;
	localparam logic [127:0] W3 = 128'h13579bdf02468ace13579bdf02468ace;
	localparam logic [127:0] W4 = 128'hc3c3c3c3c3c3c3c33c3c3c3c3c3c3c3c;

	initial begin
		forever #4 clk = ~clk;
	end

	dnp_user_model u_user (.clk_sys_i(clk), .rst_n_i(rst_n), .init_done_i(init_done), .init_start_o(init_start));

	dnp_port DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .init_start_i(init_start), .init_done_o(init_done),
		.cmd_valid_i(cv), .cmd_rdy_o(crdy), .cmd_i(cmd), .cmd_burst_cnt_i(cnt), .ofly_burst_len_i(ofly),
		.addr_i(addr), .datain_rdy_o(drdy), .write_data_i(wd), .data_mask_i(dm), .read_data_o(rd),
		.read_data_valid_o(rdv), .ext_auto_ref_i(ref_req), .ext_auto_ref_ack_o(ref_ack),
		.write_levelling_failure_o(wlf), .read_training_failure_o(rtf), .memory_termination_control_o(odt),
		.phy_wl_fail_i(wlp), .phy_rt_fail_i(rtp), .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_we_i(rwe),
		.reg_re_i(rre), .reg_rdata_o(rrd));

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d.", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk_w(input string nm, input logic [127:0] e, input logic [127:0] s);
		tests_run++;
		if (e !== s) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk_v(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (e !== s) begin
			n_mismatch++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	task automatic hang(input string nm);
		n_mismatch++;
		$display("[FAIL] %s expected response seen timeout", nm);
		end_sim();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		rwe <= 1'b1;
		ra <= a;
		rwd <= d;
		@(posedge clk);
		rwe <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rre <= 1'b1;
		ra <= a;
		@(posedge clk);
		rre <= 1'b0;
		@(posedge clk);
		d = rrd;
	endtask

	// Fields stay put through the edge that shows the ready pulse.
	task automatic send(input logic [3:0] c, input logic [4:0] n, input logic o, input logic [26:0] a);
		int i;
		i = 0;
		@(posedge clk);
		cv <= 1'b1;
		cmd <= c;
		cnt <= n;
		ofly <= o;
		addr <= a;
		do begin
			@(posedge clk);
			i++;
		end while (crdy !== 1'b1 && i < 100);
		if (crdy !== 1'b1) hang("cmd_rdy");
		cv <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] c, input logic [4:0] n, input logic o, input logic [26:0] a, input logic [15:0] m);
		int i;
		send(c, n, o, a);
		for (int k = 0; k < n; k++) begin
			i = 0;
			do begin
				@(posedge clk);
				i++;
			end while (drdy !== 1'b1 && i < 50);
			if (drdy !== 1'b1) hang("datain_rdy");
			chk_v("termination", 32'h1, {31'h0, odt});
			wd <= wq[k];
			dm <= m;
		end
		repeat (6) @(posedge clk);
		chk_v("termination idle", 32'h0, {31'h0, odt});
	endtask

	// Counts every valid word over a window long enough for 32 repeats.
	task automatic rdc(input logic [3:0] c, input logic [4:0] n, input logic o, input logic [26:0] a, input int e);
		send(c, n, o, a);
		got.delete();
		repeat (80) begin
			@(posedge clk);
			if (rdv === 1'b1) got.push_back(rd);
		end
		chk_v("read count", e, got.size());
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_init();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (init_done !== 1'b1 && i < 600);
		if (init_done !== 1'b1) hang("init_done");
		chk_v("wl failure", 32'h0, {31'h0, wlf});
		chk_v("rt failure", 32'h0, {31'h0, rtf});
		@(posedge clk);
		chk_v("init_done width", 32'h0, {31'h0, init_done});
		reg_rd(`DNP_REG_CTRL, v);
		chk_v("ctrl reset", 32'h2, {24'h0, v});
		reg_rd(`DNP_REG_STAT, v);
		chk_v("status", 32'h1, {24'h0, v});
		reg_wr(4'h7, 8'hff);
		reg_rd(4'h7, v);
		chk_v("unmapped", 32'h0, {24'h0, v});
		$display("Test init done.");
	endtask

	// Fixed BL8: the on-the-fly input is driven both high and low and must be ignored.
	task automatic t_fixed();
		wq = '{W0, W1};
		wr(`DNP_CMD_WRITE, 5'h02, 1'b1, 27'h0, 16'h0);
		wq = '{W4};
		wr(`DNP_CMD_WRITE, 5'h01, 1'b0, 27'h0, 16'h00ff);
		rdc(`DNP_CMD_READ, 5'h02, 1'b0, 27'h0, 2);
		chk_w("masked word", {W4[127:64], W0[63:0]}, got[0]);
		chk_w("second word", W1, got[1]);
		// A single read at the stepped address proves the write advanced by eight.
		rdc(`DNP_CMD_READ, 5'h01, 1'b1, 27'h8, 1);
		chk_w("stepped word", W1, got[0]);
		$display("Test fixed burst done.");
	endtask

	task automatic t_ofly();
		reg_wr(`DNP_REG_CTRL, 8'h01);
		reg_rd(`DNP_REG_CTRL, v);
		chk_v("ctrl on-the-fly", 32'h1, {24'h0, v});
		wq = '{W2, W3};
		wr(`DNP_CMD_WRITEA, 5'h02, 1'b0, 27'h10, 16'h0);
		rdc(`DNP_CMD_READA, 5'h02, 1'b0, 27'h10, 2);
		chk_w("chop word 0", W2, got[0]);
		chk_w("chop word 1", W3, got[1]);
		rdc(`DNP_CMD_READ, 5'h01, 1'b1, 27'h14, 1);
		chk_w("chop step", W3, got[0]);
		rdc(`DNP_CMD_READ, 5'h00, 1'b1, 27'h0, 32);
		$display("Test on-the-fly done.");
	endtask

	task automatic t_ref();
		int i;
		i = 0;
		@(posedge clk);
		ref_req <= 1'b1;
		do begin
			@(posedge clk);
			i++;
		end while (ref_ack !== 1'b1 && i < 60);
		ref_req <= 1'b0;
		chk_v("refresh ack delay", 32'h16, i);
		@(posedge clk);
		chk_v("refresh ack width", 32'h0, {31'h0, ref_ack});
		// A refresh command runs the same wait but never acknowledges.
		send(`DNP_CMD_REFRESH, 5'h01, 1'b0, 27'h0);
		reg_rd(`DNP_REG_STAT, v);
		chk_v("refresh busy", 32'h9, {24'h0, v});
		i = 0;
		repeat (25) begin
			@(posedge clk);
			if (ref_ack === 1'b1) i++;
		end
		chk_v("command refresh ack", 32'h0, i);
		reg_rd(`DNP_REG_STAT, v);
		chk_v("refresh over", 32'h1, {24'h0, v});
		$display("Test refresh done.");
	endtask

	// A second reset in mid-run with failing levelling and training.
	task automatic t_fail();
		int i;
		i = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		wlp <= 1'b1;
		rtp <= 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		do begin
			@(posedge clk);
			i++;
		end while (init_done !== 1'b1 && i < 600);
		if (init_done !== 1'b1) hang("init_done again");
		chk_v("wl failure set", 32'h1, {31'h0, wlf});
		chk_v("rt failure set", 32'h1, {31'h0, rtf});
		reg_rd(`DNP_REG_STAT, v);
		chk_v("status failure", 32'h7, {24'h0, v});
		reg_rd(`DNP_REG_CTRL, v);
		chk_v("ctrl after reset", 32'h2, {24'h0, v});
		$display("Test mid-run reset done.");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_init();
		t_fixed();
		t_ofly();
		t_ref();
		t_fail();
		end_sim();
	end
endmodule
`default_nettype wire
